//--- design/scd_command_decoder.sv
// command decode front end of a four-bank synchronous dram
`timescale 1ns/1ps
`include "scd_params.svh"

module scd_command_decoder (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic                       clk_en,
  input  wire logic                       org_x32,
  input  wire logic                       cs_n,
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic                       cke,
  input  wire logic                       bank_sel_lo,
  input  wire logic                       bank_sel_hi,
  input  wire logic [`SCD_ADDR_W-1:0]     addr,
  input  wire logic                       lower_byte_mask,
  input  wire logic                       upper_byte_mask,
  input  wire logic                       lane0_mask,
  input  wire logic                       lane1_mask,
  input  wire logic                       lane2_mask,
  input  wire logic                       lane3_mask,
  output scd_pkg::scd_dec_t               dec_out,
  output logic                            dec_valid,
  output logic [`SCD_ROW_W-1:0]           refresh_row,
  output logic [`SCD_ADDR_W-1:0]          mode_reg,
  output logic [`SCD_ADDR_W-1:0]          ext_mode_reg,
  output logic [`SCD_NBANK-1:0]           bank_open,
  output logic [`SCD_NBANK*`SCD_ROW_W-1:0] open_rows,
  output logic                            self_refresh,
  output logic [`SCD_MASK_W-1:0]          wr_lane_en,
  output logic [`SCD_MASK_W-1:0]          rd_lane_oe
);

  // pin sample chain: pins come from outside, two flops before decode
  scd_pkg::scd_pins_t pins_raw;
  scd_pkg::scd_pins_t pins_s1_q;
  scd_pkg::scd_pins_t pins_q;
  // all six mask pins are synchronised; the lane choice is made after the flops
  logic [`SCD_MASK_W+1:0] mask_raw;
  logic [`SCD_MASK_W+1:0] mask_s1_q;
  logic [`SCD_MASK_W+1:0] mask_q;
  logic [`SCD_MASK_W-1:0] mask_sel;
  logic                   org_s1_q;
  logic                   org_q;

  // lane mapping of the synchronised mask pins per organisation
  // m holds {upper, lower, lane3, lane2, lane1, lane0}
  function automatic logic [`SCD_MASK_W-1:0] lane_masks(input logic                   x32,
                                                         input logic [`SCD_MASK_W+1:0] m);
    if (x32) begin
      return m[`SCD_MASK_W-1:0];
    end
    // x16 uses lanes 0 and 1 only; upper lanes stay blocked
    return {2'h3, m[`SCD_MASK_W+1:`SCD_MASK_W]};
  endfunction

  // muxing raw pins ahead of the flops would let a mode change glitch the lanes
  always_comb begin
    pins_raw = '{cs_n: cs_n, ras_n: ras_n, cas_n: cas_n, we_n: we_n, cke: cke,
                 bank_sel_hi: bank_sel_hi, bank_sel_lo: bank_sel_lo, addr: addr};
    mask_raw = {upper_byte_mask, lower_byte_mask, lane3_mask, lane2_mask, lane1_mask, lane0_mask};
    mask_sel = lane_masks(org_q, mask_q);
  end

  // sampled on rising clock edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pins_s1_q <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1,
                     bank_sel_hi: 1'b0, bank_sel_lo: 1'b0, addr: 12'h000};
      pins_q    <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1,
                     bank_sel_hi: 1'b0, bank_sel_lo: 1'b0, addr: 12'h000};
      mask_s1_q <= 6'h3F;
      mask_q    <= 6'h3F;
      org_s1_q  <= 1'b0;
      org_q     <= 1'b0;
    end else if (clk_en) begin
      pins_s1_q <= pins_raw;
      pins_q    <= pins_s1_q;
      mask_s1_q <= mask_raw;
      mask_q    <= mask_s1_q;
      org_s1_q  <= org_x32;
      org_q     <= org_s1_q;
    end
  end

  // strobe decode of the synchronised pins
  function automatic scd_pkg::scd_cmd_t decode_cmd(input scd_pkg::scd_pins_t p);
    if (p.cs_n) begin
      return scd_pkg::SCD_CMD_INHIBIT;
    end
    unique case ({p.ras_n, p.cas_n, p.we_n})
      3'b111:  return scd_pkg::SCD_CMD_NOP;
      3'b011:  return scd_pkg::SCD_CMD_ACTIVATE;
      3'b101:  return scd_pkg::SCD_CMD_READ;
      3'b100:  return scd_pkg::SCD_CMD_WRITE;
      3'b110:  return scd_pkg::SCD_CMD_BURST_END;
      3'b010:  return scd_pkg::SCD_CMD_PRECHARGE;
      3'b001:  return p.cke ? scd_pkg::SCD_CMD_AUTO_REF : scd_pkg::SCD_CMD_SELF_REF;
      3'b000: begin
        unique case ({p.bank_sel_hi, p.bank_sel_lo})
          2'b00:   return scd_pkg::SCD_CMD_MODE_LOAD;
          2'b10:   return scd_pkg::SCD_CMD_EXT_LOAD;
          default: return scd_pkg::SCD_CMD_RSV_LOAD;
        endcase
      end
    endcase
  endfunction

  // decoded command and operands for this cycle
  scd_pkg::scd_dec_t dec_now;
  always_comb begin
    dec_now           = '0;
    dec_now.cmd       = decode_cmd(pins_q);
    dec_now.bank      = {pins_q.bank_sel_hi, pins_q.bank_sel_lo};
    dec_now.row       = pins_q.addr;
    // x32 column is eight bits wide; bit 8 forced low
    dec_now.col       = org_q ? {1'b0, pins_q.addr[`SCD_COL32_W-1:0]}
                              : pins_q.addr[`SCD_COL16_W-1:0];
    dec_now.auto_pre  = pins_q.addr[`SCD_PRE_BIT] &&
                        (dec_now.cmd == scd_pkg::SCD_CMD_READ ||
                         dec_now.cmd == scd_pkg::SCD_CMD_WRITE);
    dec_now.all_banks = pins_q.addr[`SCD_PRE_BIT] &&
                        (dec_now.cmd == scd_pkg::SCD_CMD_PRECHARGE);
    if (dec_now.cmd == scd_pkg::SCD_CMD_AUTO_REF || dec_now.cmd == scd_pkg::SCD_CMD_SELF_REF) begin
      // refresh ignores address and bank pins
      dec_now.bank = 2'h0;
      dec_now.row  = refresh_row;
      dec_now.col  = 9'h000;
    end
  end

  // state next values: bank table, mode registers, refresh counter
  logic [`SCD_NBANK-1:0]            bank_open_d;
  logic [`SCD_NBANK*`SCD_ROW_W-1:0] open_rows_d;
  logic [`SCD_ADDR_W-1:0]           mode_reg_d;
  logic [`SCD_ADDR_W-1:0]           ext_mode_reg_d;
  logic [`SCD_ROW_W-1:0]            refresh_row_d;
  logic                             self_refresh_d;
  logic [`SCD_MASK_W-1:0]           rd_pipe1_d;
  logic [`SCD_MASK_W-1:0]           rd_pipe1_q;

  always_comb begin
    bank_open_d    = bank_open;
    open_rows_d    = open_rows;
    mode_reg_d     = mode_reg;
    ext_mode_reg_d = ext_mode_reg;
    refresh_row_d  = refresh_row;
    self_refresh_d = self_refresh;
    // leave self refresh once clock enable returns high
    if (self_refresh && pins_q.cke) begin
      self_refresh_d = 1'b0;
    end
    unique case (dec_now.cmd)
      scd_pkg::SCD_CMD_ACTIVATE: begin
        bank_open_d[dec_now.bank] = 1'b1;
        open_rows_d[dec_now.bank*`SCD_ROW_W +: `SCD_ROW_W] = dec_now.row;
      end
      scd_pkg::SCD_CMD_PRECHARGE: begin
        if (dec_now.all_banks) begin
          bank_open_d = '0;
        end else begin
          bank_open_d[dec_now.bank] = 1'b0;
        end
      end
      scd_pkg::SCD_CMD_AUTO_REF: begin
        refresh_row_d = refresh_row + 12'h001;
      end
      scd_pkg::SCD_CMD_SELF_REF: begin
        self_refresh_d = 1'b1;
      end
      scd_pkg::SCD_CMD_MODE_LOAD: begin
        mode_reg_d = pins_q.addr;
      end
      scd_pkg::SCD_CMD_EXT_LOAD: begin
        ext_mode_reg_d = pins_q.addr;
      end
      default: begin
        // inhibit, nop, read, write, terminate, reserved load: no state change
      end
    endcase
  end

  // registered outputs; masks gate writes at once, read enables two clocks on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dec_out      <= '0;
      dec_valid    <= 1'b0;
      bank_open    <= '0;
      open_rows    <= '0;
      mode_reg     <= `SCD_MODE_RST;
      ext_mode_reg <= `SCD_MODE_RST;
      refresh_row  <= `SCD_REFROW_RST;
      self_refresh <= 1'b0;
      wr_lane_en   <= '0;
      rd_pipe1_q   <= '0;
      rd_lane_oe   <= '0;
    end else if (clk_en) begin
      dec_out      <= dec_now;
      dec_valid    <= dec_now.cmd != scd_pkg::SCD_CMD_INHIBIT &&
                      dec_now.cmd != scd_pkg::SCD_CMD_NOP;
      bank_open    <= bank_open_d;
      open_rows    <= open_rows_d;
      mode_reg     <= mode_reg_d;
      ext_mode_reg <= ext_mode_reg_d;
      refresh_row  <= refresh_row_d;
      self_refresh <= self_refresh_d;
      wr_lane_en   <= ~mask_sel;
      rd_pipe1_q   <= rd_pipe1_d;
      rd_lane_oe   <= rd_pipe1_q;
    end
  end

  // read enables trail the write enables by two whole clocks
  always_comb begin
    rd_pipe1_d = wr_lane_en;
  end

  // bit 11 of the op-code is kept but has no meaning here
  logic unused_rsv;
  always_comb begin
    unused_rsv = mode_reg[`SCD_RSV_BIT];
  end

  a_inhibit_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && pins_q.cs_n |=> !dec_valid && dec_out.cmd == scd_pkg::SCD_CMD_INHIBIT)
    else $error("command taken while deselected");

  a_nop_keeps: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && dec_now.cmd == scd_pkg::SCD_CMD_NOP |=> $stable(bank_open))
    else $error("nop changed bank state");

  a_read_decode: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && !pins_q.cs_n && {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} == 3'b101
    |=> dec_out.cmd == scd_pkg::SCD_CMD_READ)
    else $error("read pattern misdecoded");

  a_activate_opens: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && dec_now.cmd == scd_pkg::SCD_CMD_ACTIVATE
    |=> bank_open[$past(dec_now.bank)] && dec_out.row == $past(pins_q.addr))
    else $error("activate did not open bank");

  a_autopre_once: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && dec_now.cmd != scd_pkg::SCD_CMD_READ && dec_now.cmd != scd_pkg::SCD_CMD_WRITE
    |=> !dec_out.auto_pre)
    else $error("auto precharge persisted");

  a_pre_all: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && dec_now.cmd == scd_pkg::SCD_CMD_PRECHARGE && pins_q.addr[`SCD_PRE_BIT]
    |=> bank_open == 4'h0)
    else $error("precharge all left a bank open");

  a_pre_one: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && dec_now.cmd == scd_pkg::SCD_CMD_PRECHARGE && !pins_q.addr[`SCD_PRE_BIT]
    |=> !bank_open[$past(dec_now.bank)])
    else $error("single bank precharge left bank open");

  a_self_entry: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && dec_now.cmd == scd_pkg::SCD_CMD_SELF_REF |=> self_refresh && !$past(pins_q.cke))
    else $error("self refresh not entered");

  a_refresh_count: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && dec_now.cmd == scd_pkg::SCD_CMD_AUTO_REF
    |=> refresh_row == $past(refresh_row) + 12'h001)
    else $error("refresh counter did not advance");

  a_refresh_row: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && dec_now.cmd == scd_pkg::SCD_CMD_AUTO_REF |=> dec_out.row == $past(refresh_row))
    else $error("refresh row not from counter");

  a_ext_load: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && dec_now.cmd == scd_pkg::SCD_CMD_EXT_LOAD |=> ext_mode_reg == $past(pins_q.addr)
    && $stable(mode_reg))
    else $error("extended load wrong");

  a_read_mask_lag: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en [*2] |=> rd_lane_oe == $past(wr_lane_en, 2))
    else $error("read mask delay not two clocks");

  a_upper_blocked: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && !org_q |=> wr_lane_en[3:2] == 2'h0)
    else $error("x16 enabled an upper lane");

endmodule // scd_command_decoder

//--- design/scd_params.svh
// constants of the command decoder: field positions, widths, reset values
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH
`define SCD_ADDR_W        12
`define SCD_ROW_W         12
`define SCD_COL16_W       9
`define SCD_COL32_W       8
`define SCD_OPC_W         11
`define SCD_PRE_BIT       10
`define SCD_RSV_BIT       11
`define SCD_NBANK         4
`define SCD_DQ_W          32
`define SCD_MASK_W        4
`define SCD_READ_MASK_DLY 2
`define SCD_REFROW_RST    12'h000
`define SCD_MODE_RST      12'h000
`endif

//--- design/scd_pkg.sv
// types shared by the command decoder
package scd_pkg;
  typedef enum logic [3:0] {
    SCD_CMD_INHIBIT   = 4'h0,
    SCD_CMD_NOP       = 4'h1,
    SCD_CMD_ACTIVATE  = 4'h2,
    SCD_CMD_READ      = 4'h3,
    SCD_CMD_WRITE     = 4'h4,
    SCD_CMD_BURST_END = 4'h5,
    SCD_CMD_PRECHARGE = 4'h6,
    SCD_CMD_AUTO_REF  = 4'h7,
    SCD_CMD_SELF_REF  = 4'h8,
    SCD_CMD_MODE_LOAD = 4'h9,
    SCD_CMD_EXT_LOAD  = 4'hA,
    SCD_CMD_RSV_LOAD  = 4'hB
  } scd_cmd_t;

  // one decoded command with its operands
  typedef struct packed {
    scd_cmd_t    cmd;
    logic [1:0]  bank;
    logic [11:0] row;
    logic [8:0]  col;
    logic        auto_pre;
    logic        all_banks;
  } scd_dec_t;

  // command pins as sampled
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        cke;
    logic        bank_sel_hi;
    logic        bank_sel_lo;
    logic [11:0] addr;
  } scd_pins_t;
endpackage

//--- dv/scd_ctrl_model.sv
// memory controller model driving command pins and byte masks
`timescale 1ns/1ps

module scd_ctrl_model (
  input  wire logic          clk,
  output scd_pkg::scd_pins_t pins,
  output logic [3:0]         lane_masks,
  output logic [1:0]         byte_masks
);
  // idle: deselected, clock enable high, all lanes blocked
  initial begin
    pins = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1,
             bank_sel_hi: 1'b0, bank_sel_lo: 1'b0, addr: 12'h000};
    lane_masks = 4'hF;
    byte_masks = 2'h3;
  end

  // one command for one cycle, then a no-operation with scrambled operands
  task automatic send(input logic [3:0] strb, input logic ck, input logic [1:0] bank, input logic [11:0] a);
    @(posedge clk);
    #1;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = strb;
    pins.cke = ck;
    {pins.bank_sel_hi, pins.bank_sel_lo} = bank;
    pins.addr = a;
    @(posedge clk);
    #1;
    // cke stays where the command left it so self refresh is not left at once
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'h7;
    {pins.bank_sel_hi, pins.bank_sel_lo} = ~bank;
    pins.addr = ~a; // don't-care lines never repeat the last value
  endtask

  // masks change just after an edge, like every other pin
  task automatic set_masks(input logic [3:0] lm, input logic [1:0] bm);
    @(posedge clk);
    #1;
    lane_masks = lm;
    byte_masks = bm;
  endtask
endmodule // scd_ctrl_model

//--- dv/tb.sv
// self-checking bench of the command decoder
`timescale 1ns/1ps
`include "scd_params.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end

module tb;
  logic                            clk;
  logic                            arst_n;
  logic                            clk_en;
  logic                            org_x32;
  scd_pkg::scd_pins_t              pins;
  logic [3:0]                      lane_masks;
  logic [1:0]                      byte_masks;
  scd_pkg::scd_dec_t               dec_out;
  logic                            dec_valid;
  logic [`SCD_ROW_W-1:0]           refresh_row;
  logic [`SCD_ADDR_W-1:0]          mode_reg;
  logic [`SCD_ADDR_W-1:0]          ext_mode_reg;
  logic [`SCD_NBANK-1:0]           bank_open;
  logic [`SCD_NBANK*`SCD_ROW_W-1:0] open_rows;
  logic                            self_refresh;
  logic [3:0]                      wr_lane_en;
  logic [3:0]                      rd_lane_oe;
  logic [3:0]                      prev_en;
  int                              num_errors;
  int                              tests_run;

  scd_ctrl_model u_ctl (.clk(clk), .pins(pins), .lane_masks(lane_masks), .byte_masks(byte_masks));

  scd_command_decoder u_dut (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .org_x32(org_x32),
    .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n), .cke(pins.cke),
    .bank_sel_lo(pins.bank_sel_lo), .bank_sel_hi(pins.bank_sel_hi), .addr(pins.addr),
    .lower_byte_mask(byte_masks[0]), .upper_byte_mask(byte_masks[1]),
    .lane0_mask(lane_masks[0]), .lane1_mask(lane_masks[1]),
    .lane2_mask(lane_masks[2]), .lane3_mask(lane_masks[3]),
    .dec_out(dec_out), .dec_valid(dec_valid), .refresh_row(refresh_row), .mode_reg(mode_reg),
    .ext_mode_reg(ext_mode_reg), .bank_open(bank_open), .open_rows(open_rows),
    .self_refresh(self_refresh), .wr_lane_en(wr_lane_en), .rd_lane_oe(rd_lane_oe));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // verdict and end of run
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // issue a command; decode lands three edges after the pins
  task automatic op(input logic [3:0] s, input logic ck, input logic [1:0] b, input logic [11:0] a,
                    input scd_pkg::scd_cmd_t c, input logic v);
    u_ctl.send(s, ck, b, a);
    repeat (2) @(posedge clk);
    #1;
    `CHK(dec_out.cmd, c)
    `CHK(dec_valid, v)
  endtask

  // write lanes follow masks at once, read lanes two clocks later
  task automatic mask_step(input logic [3:0] lm, input logic [1:0] bm, input logic [3:0] exp);
    u_ctl.set_masks(lm, bm);
    repeat (3) @(posedge clk);
    #1;
    `CHK(wr_lane_en, exp)
    @(posedge clk);
    #1;
    `CHK(rd_lane_oe, prev_en)
    @(posedge clk);
    #1;
    `CHK(rd_lane_oe, exp)
    prev_en = exp;
  endtask

  // watchdog, far beyond the roughly 120 cycles the tests need
  initial begin
    #80000;
    num_errors++;
    test_done();
  end

  // main sequence
  initial begin
    num_errors = 0;
    tests_run = 0;
    arst_n = 1'b0;
    clk_en = 1'b1;
    org_x32 = 1'b0;
    prev_en = 4'h0;
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    `CHK(bank_open, 4'h0)
    `CHK(mode_reg, `SCD_MODE_RST)
    `CHK(refresh_row, `SCD_REFROW_RST)
    op(4'b0011, 1'b1, 2'd2, 12'h123, scd_pkg::SCD_CMD_ACTIVATE, 1'b1);
    `CHK({dec_out.bank, dec_out.row}, {2'd2, 12'h123})
    op(4'b0011, 1'b1, 2'd1, 12'hFFF, scd_pkg::SCD_CMD_ACTIVATE, 1'b1);
    `CHK(bank_open, 4'b0110)
    `CHK({open_rows[35:24], open_rows[23:12]}, {12'h123, 12'hFFF})
    op(4'b0101, 1'b1, 2'd2, 12'h5A5, scd_pkg::SCD_CMD_READ, 1'b1);
    `CHK({dec_out.bank, dec_out.col, dec_out.auto_pre}, {2'd2, 9'h1A5, 1'b1})
    op(4'b0100, 1'b1, 2'd1, 12'hBFF, scd_pkg::SCD_CMD_WRITE, 1'b1);
    `CHK({dec_out.bank, dec_out.col, dec_out.auto_pre}, {2'd1, 9'h1FF, 1'b0})
    op(4'b0110, 1'b1, 2'd0, 12'h400, scd_pkg::SCD_CMD_BURST_END, 1'b1);
    op(4'b0111, 1'b1, 2'd0, 12'h000, scd_pkg::SCD_CMD_NOP, 1'b0);
    `CHK(bank_open, 4'b0110)
    // clock enable low freezes the sampler: an activate on the pins is lost
    clk_en = 1'b0;
    u_ctl.send(4'b0011, 1'b1, 2'd3, 12'h0F0);
    repeat (3) @(posedge clk);
    #1;
    `CHK({dec_valid, bank_open}, {1'b0, 4'b0110})
    clk_en = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK({dec_valid, bank_open}, {1'b0, 4'b0110})
    op(4'b0010, 1'b1, 2'd1, 12'h000, scd_pkg::SCD_CMD_PRECHARGE, 1'b1);
    `CHK({dec_out.all_banks, bank_open}, {1'b0, 4'b0100})
    op(4'b0010, 1'b1, 2'd1, 12'h400, scd_pkg::SCD_CMD_PRECHARGE, 1'b1);
    `CHK({dec_out.all_banks, bank_open}, {1'b1, 4'b0000})
    op(4'b0001, 1'b1, 2'd3, 12'hFFF, scd_pkg::SCD_CMD_AUTO_REF, 1'b1);
    `CHK({dec_out.bank, dec_out.row, dec_out.col, refresh_row}, {2'd0, 12'h000, 9'h000, 12'h001})
    op(4'b0001, 1'b0, 2'd3, 12'hFFF, scd_pkg::SCD_CMD_SELF_REF, 1'b1);
    `CHK({self_refresh, refresh_row}, {1'b1, 12'h001})
    u_ctl.send(4'b0111, 1'b1, 2'd0, 12'h000);
    repeat (4) @(posedge clk);
    #1;
    `CHK(self_refresh, 1'b0)
    // banks are idle here, so mode loads are legal
    op(4'b0000, 1'b1, 2'd0, 12'hABC, scd_pkg::SCD_CMD_MODE_LOAD, 1'b1);
    `CHK(mode_reg, 12'hABC)
    op(4'b0000, 1'b1, 2'd2, 12'h01F, scd_pkg::SCD_CMD_EXT_LOAD, 1'b1);
    `CHK(ext_mode_reg, 12'h01F)
    for (int b = 1; b < 4; b += 2) begin
      op(4'b0000, 1'b1, b[1:0], 12'h555, scd_pkg::SCD_CMD_RSV_LOAD, 1'b1);
      `CHK({mode_reg, ext_mode_reg}, {12'hABC, 12'h01F})
    end
    op(4'b1000, 1'b1, 2'd0, 12'h777, scd_pkg::SCD_CMD_INHIBIT, 1'b0);
    `CHK(mode_reg, 12'hABC)
    // a deselected refresh pattern must not step the counter
    op(4'b1001, 1'b1, 2'd0, 12'h000, scd_pkg::SCD_CMD_INHIBIT, 1'b0);
    `CHK({self_refresh, refresh_row}, {1'b0, 12'h001})
    // x16 masks; lane masks set to differ from the byte masks to expose a wrong pin choice
    mask_step(4'b1010, 2'b01, 4'b0010);
    mask_step(4'b1111, 2'b10, 4'b0001);
    org_x32 = 1'b1;
    // lane masks are still all high, so every lane ends up disabled
    prev_en = 4'h0;
    repeat (4) @(posedge clk);
    mask_step(4'b0110, 2'b00, 4'b1001);
    mask_step(4'b1000, 2'b11, 4'b0111);
    op(4'b0011, 1'b1, 2'd0, 12'h0AA, scd_pkg::SCD_CMD_ACTIVATE, 1'b1);
    op(4'b0101, 1'b1, 2'd0, 12'h5FF, scd_pkg::SCD_CMD_READ, 1'b1);
    `CHK({dec_out.col, dec_out.auto_pre}, {9'h0FF, 1'b1})
    test_done();
  end
endmodule // tb
